// ---- design/rwd_pkg.sv ----
package rwd_pkg;

  // bus geometry
  localparam int         ADDR_W = 8;
  localparam int         DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] KEY_IDX   = 8'h1d;
  localparam logic [7:0] CTRL_IDX  = 8'h1e;
  localparam logic [7:0] LCLR_IDX  = 8'h1f;
  localparam logic [7:0] KEY_ADDR  = {KEY_IDX[5:0], 2'b00};
  localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] LCLR_ADDR = {LCLR_IDX[5:0], 2'b00};

  // control and legacy clear register fields
  localparam int         TSEL_LO_BIT = 0;
  localparam int         TSEL_HI_BIT = 1;
  localparam int         WDEN_BIT    = 2;
  localparam int         CLKMON_BIT  = 3;
  localparam int         FLAG_BIT    = 4;
  localparam int         LCLR_BIT    = 0;

  // reset values and keys
  localparam logic [7:0] KEY_RESET   = 8'h00;
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'haa;
  localparam logic [1:0] TSEL_RESET  = 2'h0;

  // timing
  localparam int         CLK_PERIOD_NS     = 50;
  localparam int         POR_DELAY_CYCLES  = 4064;
  localparam int         INT_RST_CYCLES    = 4;
  localparam int         CLKMON_TIMEOUT_NS = 5000;
  localparam int         CLKMON_RAW        = CLKMON_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int         CLKMON_CYCLES     = (CLKMON_RAW < 1) ? 1 : CLKMON_RAW;
  localparam int         CLKMON_W          = 8;
  localparam int         DLY_W             = 12;
  localparam int         TSEL_STEP_LOG2    = 2;

  // reset sequencer states
  typedef enum logic [2:0] {
    ST_POR_DELAY,
    ST_WAIT_PIN,
    ST_PIN_HOLD,
    ST_INT_RESET,
    ST_START,
    ST_RUN
  } rwd_state_t;

endpackage

// ---- design/rwd_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
module rwd_sync2 #(
  parameter int               WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // two flops per bit; stage one feeds only stage two
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_q <= RST_VAL[i];
        sync_q <= RST_VAL[i];
      end
      else
      begin
        meta_q <= d[i];
        sync_q <= meta_q;
      end
    end
    assign q[i] = sync_q;
  end

endmodule // rwd_sync2
`default_nettype wire

// ---- design/rwd_wdt_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
module rwd_wdt_counter #(
  parameter int CW = 22
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [5:0] shift,
  // timeout
  output logic            expire
);

  logic [CW-1:0] cnt_q;
  logic          expire_q;
  logic [CW-1:0] limit;
  logic          hit;

  // period is two to the power of shift cycles
  assign limit  = (CW'(1) << shift) - CW'(1);
  assign hit    = run & (cnt_q == limit);
  assign expire = expire_q;

  // a restart in the hit cycle wins, so a just-in-time service still saves us
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q    <= '0;
      expire_q <= 1'b0;
    end
    else
    begin
      cnt_q    <= (!run || restart || hit) ? '0 : cnt_q + CW'(1);
      expire_q <= hit & ~restart; // R21
    end
  end

  property p_restart_clears;
    @(posedge clk) disable iff (!rst_n)
    (run && restart) |=> (cnt_q == '0) && !expire_q;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear timer"); // R12

  property p_expire_at_limit;
    @(posedge clk) disable iff (!rst_n)
    (run && !restart && cnt_q == limit) |=> expire_q;
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) else $error("timer missed its limit"); // R21

endmodule // rwd_wdt_counter
`default_nettype wire

// ---- design/rwd_top.sv ----
// Functional notes
// R1 - four sources reset whole processor
// R2 - reset aborts, clears controls, loads vector
// R3 - hold reset 4064 cycles after power-on
// R4 - primary mode drives pin low during delay
// R5 - stay reset while pin low after delay
// R6 - pin input-only legacy, open-drain primary
// R7 - external low must last 1.5 cycles
// R8 - primary mode pulls pin on internal resets
// R9 - sequence starts on edge after pin rise
// R10 - primary watchdog starts on enable bit
// R11 - legacy watchdog enabled by option fuse
// R12 - service needs 0x55 then 0xaa
// R13 - any traffic allowed between key writes
// R14 - software services within every timeout period
// R15 - expiry causes full system reset
// R16 - key register write-only, reads harmless
// R17 - flag set on resets, read clears
// R18 - clock monitor enable writable once
// R19 - enable and select written once per reset
// R20 - control bits 7-5 read zero
// R21 - timeout two-to-fifteen times 1/4/16/64
// R22 - clock loss detected causes reset
// R23 - legacy clear by writing zero bit0
// R24 - wrong key leaves sequence incomplete
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module rwd_top #(
  parameter int BASE_DIV_LOG2   = 15,
  parameter int LEGACY_DIV_LOG2 = 17
) (
  // apb slave
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rwd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [rwd_pkg::DATA_W-1:0] pwdata,
  output logic      [rwd_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // open-drain reset pin
  input  wire logic                       reset_pin_in,
  output logic                            reset_pin_out,
  output logic                            reset_pin_oe,
  // configuration straps
  input  wire logic                       primary_config_mode,
  input  wire logic                       legacy_watchdog_fuse,
  // toggles while the internal bus clock runs
  input  wire logic                       bus_clk_tick,
  // to the processor
  output logic                            sys_reset,
  output logic                            vector_load,
  output logic                            watchdog_reset_flag
);

  localparam int WDT_W = ((BASE_DIV_LOG2 + 6 > LEGACY_DIV_LOG2) ? BASE_DIV_LOG2 + 6 : LEGACY_DIV_LOG2) + 1;

  // synchronised pins
  logic [3:0] sync_q;
  logic       pin_s;
  logic       primary_s;
  logic       fuse_s;
  logic       tick_s;

  rwd_sync2 #(
    .WIDTH   (4),
    .RST_VAL (4'h0)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({bus_clk_tick, legacy_watchdog_fuse, primary_config_mode, reset_pin_in}),
    .q     (sync_q)
  );

  assign pin_s     = sync_q[0];
  assign primary_s = sync_q[1];
  assign fuse_s    = sync_q[2];
  assign tick_s    = sync_q[3];

  // state
  rwd_pkg::rwd_state_t        state_q;
  rwd_pkg::rwd_state_t        state_d;
  logic [rwd_pkg::DLY_W-1:0]  dly_q;
  logic [rwd_pkg::DLY_W-1:0]  dly_d;
  logic                       sys_reset_q;
  logic                       vector_load_q;
  logic                       pin_oe_q;
  logic                       pin_out_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic [rwd_pkg::DATA_W-1:0] prdata_q;
  logic                       wden_q;
  logic [1:0]                 tsel_q;
  logic                       cfg_locked_q;
  logic                       clkmon_en_q;
  logic                       clkmon_locked_q;
  logic                       flag_q;
  logic                       key_armed_q;
  logic                       tick_prev_q;
  logic [rwd_pkg::CLKMON_W-1:0] loss_cnt_q;

  // bus decode
  logic       acc;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit_key;
  logic       hit_ctrl;
  logic       hit_lclr;
  logic       mapped;
  logic [7:0] wbyte;

  assign acc      = psel & penable & pready_q;
  assign wr_acc   = acc & pwrite;
  assign rd_acc   = acc & ~pwrite;
  assign hit_key  = (paddr == rwd_pkg::KEY_ADDR);
  assign hit_ctrl = (paddr == rwd_pkg::CTRL_ADDR);
  assign hit_lclr = (paddr == rwd_pkg::LCLR_ADDR);
  assign mapped   = hit_key | hit_ctrl | hit_lclr;
  assign wbyte    = pwdata[7:0];

  // reset qualifiers
  logic in_reset;
  logic running;
  logic wdt_expire;
  logic clk_fault;
  logic int_fault;

  assign in_reset  = (state_q != rwd_pkg::ST_RUN);
  assign running   = ~in_reset;
  assign int_fault = running & (wdt_expire | clk_fault);

  // key sequence; reads and other addresses in between leave it armed
  logic key_wr;
  logic key_complete;
  logic key_armed_d;

  assign key_wr       = wr_acc & hit_key;
  assign key_complete = key_wr & key_armed_q & (wbyte == rwd_pkg::KEY_SECOND); // R12 R13
  assign key_armed_d  = in_reset ? 1'b0 :
                        key_wr   ? (wbyte == rwd_pkg::KEY_FIRST) : // R24
                        key_armed_q;

  // watchdog steering, primary register or legacy fuse
  logic       wdt_run;
  logic       wdt_restart;
  logic [5:0] wdt_shift;
  logic       lclr_wr;

  assign lclr_wr     = wr_acc & hit_lclr & ~pwdata[rwd_pkg::LCLR_BIT]; // R23
  assign wdt_run     = running & (primary_s ? wden_q : fuse_s); // R10 R11
  assign wdt_restart = primary_s ? key_complete : lclr_wr;
  assign wdt_shift   = primary_s ? 6'(BASE_DIV_LOG2 + rwd_pkg::TSEL_STEP_LOG2 * int'(tsel_q)) // R21
                                 : 6'(LEGACY_DIV_LOG2);

  rwd_wdt_counter #(
    .CW (WDT_W)
  ) u_wdt (
    .clk     (pclk),
    .rst_n   (presetn),
    .run     (wdt_run),
    .restart (wdt_restart),
    .shift   (wdt_shift),
    .expire  (wdt_expire)
  );

  // clock monitor: no tick edge for the window means the bus clock is gone
  logic tick_edge;
  logic clkmon_on;

  assign tick_edge = tick_s ^ tick_prev_q;
  assign clkmon_on = running & primary_s & clkmon_en_q;
  assign clk_fault = clkmon_on & (loss_cnt_q == rwd_pkg::CLKMON_W'(rwd_pkg::CLKMON_CYCLES - 1)); // R22

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_prev_q <= 1'b0;
      loss_cnt_q  <= '0;
    end
    else
    begin
      tick_prev_q <= tick_s;
      loss_cnt_q  <= (!clkmon_on || tick_edge || clk_fault) ? '0 : loss_cnt_q + 1'b1;
    end
  end

  // reset sequencer
  always_comb
  begin
    state_d = state_q;
    dly_d   = dly_q + 1'b1;
    unique case (state_q)
      rwd_pkg::ST_POR_DELAY:
      begin
        if (dly_q == rwd_pkg::DLY_W'(rwd_pkg::POR_DELAY_CYCLES - 1)) // R3
          state_d = rwd_pkg::ST_WAIT_PIN;
      end
      rwd_pkg::ST_WAIT_PIN:
      begin
        if (pin_s) // R5
          state_d = rwd_pkg::ST_START;
      end
      rwd_pkg::ST_PIN_HOLD:
      begin
        if (pin_s) // R9
          state_d = rwd_pkg::ST_START;
      end
      rwd_pkg::ST_INT_RESET:
      begin
        if (dly_q == rwd_pkg::DLY_W'(rwd_pkg::INT_RST_CYCLES - 1))
          state_d = rwd_pkg::ST_WAIT_PIN;
      end
      rwd_pkg::ST_START:
        state_d = rwd_pkg::ST_RUN; // R2
      rwd_pkg::ST_RUN:
      begin
        dly_d = '0;
        if (int_fault) // R1 R15
          state_d = rwd_pkg::ST_INT_RESET;
        else if (!pin_s) // R1
          state_d = rwd_pkg::ST_PIN_HOLD;
      end
    endcase
  end

  // pin drive only in primary mode; legacy keeps the pin an input
  logic pin_drive_d;

  assign pin_drive_d = primary_s & ((state_d == rwd_pkg::ST_POR_DELAY) | (state_d == rwd_pkg::ST_INT_RESET)); // R4 R6 R8

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q       <= rwd_pkg::ST_POR_DELAY;
      dly_q         <= '0;
      sys_reset_q   <= 1'b1;
      vector_load_q <= 1'b0;
      pin_oe_q      <= 1'b0;
      pin_out_q     <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      dly_q         <= dly_d;
      sys_reset_q   <= (state_d != rwd_pkg::ST_RUN); // R1 R2
      vector_load_q <= (state_q == rwd_pkg::ST_START); // R2
      pin_oe_q      <= pin_drive_d;
      pin_out_q     <= 1'b0;
    end
  end

  // control register writes; the lock bits make each field write-once
  logic ctrl_wr;

  assign ctrl_wr = wr_acc & hit_ctrl & running;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wden_q          <= 1'b0;
      tsel_q          <= rwd_pkg::TSEL_RESET;
      cfg_locked_q    <= 1'b0;
      clkmon_en_q     <= 1'b0;
      clkmon_locked_q <= 1'b0;
      key_armed_q     <= 1'b0;
    end
    else if (in_reset)
    begin
      wden_q          <= 1'b0; // R19
      tsel_q          <= rwd_pkg::TSEL_RESET;
      cfg_locked_q    <= 1'b0;
      clkmon_en_q     <= 1'b0;
      clkmon_locked_q <= 1'b0;
      key_armed_q     <= 1'b0;
    end
    else
    begin
      key_armed_q <= key_armed_d;
      if (ctrl_wr && !cfg_locked_q) // R19
      begin
        wden_q       <= pwdata[rwd_pkg::WDEN_BIT];
        tsel_q       <= {pwdata[rwd_pkg::TSEL_HI_BIT], pwdata[rwd_pkg::TSEL_LO_BIT]};
        cfg_locked_q <= 1'b1;
      end
      if (ctrl_wr && !clkmon_locked_q) // R18
      begin
        clkmon_en_q     <= pwdata[rwd_pkg::CLKMON_BIT];
        clkmon_locked_q <= 1'b1;
      end
    end
  end

  // flag survives the internal reset so software can see why; set beats clear
  logic flag_clr;

  assign flag_clr = rd_acc & hit_ctrl;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else
      flag_q <= int_fault | (flag_q & ~flag_clr); // R17
  end

  // read data; key and legacy clear return zero with no side effect
  logic [rwd_pkg::DATA_W-1:0] rd_mux;
  logic [7:0]                 ctrl_view;

  assign ctrl_view = {3'b000, flag_q, clkmon_en_q, wden_q, tsel_q}; // R20
  assign rd_mux    = hit_ctrl ? {{(rwd_pkg::DATA_W-8){1'b0}}, ctrl_view} : '0; // R16

  // one wait state: data are registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : '0;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign reset_pin_out       = pin_out_q;
  assign reset_pin_oe        = pin_oe_q;
  assign sys_reset           = sys_reset_q;
  assign vector_load         = vector_load_q;
  assign watchdog_reset_flag = flag_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_por_delay;
    ($past(state_q == rwd_pkg::ST_POR_DELAY) && state_q == rwd_pkg::ST_WAIT_PIN)
      |-> $past(dly_q) == rwd_pkg::DLY_W'(rwd_pkg::POR_DELAY_CYCLES - 1);
  endproperty
  a_por_delay: assert property (p_por_delay) else $error("power-on delay length wrong"); // R3

  property p_por_pin_low;
    (state_q == rwd_pkg::ST_POR_DELAY && $past(primary_s) && $past(state_q == rwd_pkg::ST_POR_DELAY))
      |-> reset_pin_oe && !reset_pin_out && sys_reset;
  endproperty
  a_por_pin_low: assert property (p_por_pin_low) else $error("pin not driven in delay"); // R4

  property p_wait_pin;
    (state_q == rwd_pkg::ST_WAIT_PIN && !pin_s) |=> state_q == rwd_pkg::ST_WAIT_PIN && sys_reset;
  endproperty
  a_wait_pin: assert property (p_wait_pin) else $error("left reset with pin low"); // R5

  property p_legacy_input;
    !$past(primary_s) |-> !reset_pin_oe;
  endproperty
  a_legacy_input: assert property (p_legacy_input) else $error("pin driven in legacy mode"); // R6

  property p_pin_rise;
    (state_q == rwd_pkg::ST_PIN_HOLD && pin_s) |=> state_q == rwd_pkg::ST_START ##1 vector_load && !sys_reset;
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("sequence did not start after pin"); // R9

  property p_expire_reset;
    (running && wdt_expire) |=> (state_q == rwd_pkg::ST_INT_RESET && sys_reset && flag_q)
      ##1 (reset_pin_oe == $past(primary_s));
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("expiry gave no reset"); // R15

  property p_flag_read;
    (flag_clr && !int_fault) |=> !flag_q;
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag not cleared by read"); // R17

  property p_clkmon_once;
    (ctrl_wr && clkmon_locked_q) |=> $stable(clkmon_en_q);
  endproperty
  a_clkmon_once: assert property (p_clkmon_once) else $error("clock monitor bit rewritten"); // R18

  property p_cfg_once;
    (ctrl_wr && cfg_locked_q) |=> $stable(wden_q) && $stable(tsel_q);
  endproperty
  a_cfg_once: assert property (p_cfg_once) else $error("enable or select rewritten"); // R19

  property p_ctrl_high_zero;
    (pready && hit_ctrl && !pwrite) |-> prdata[7:5] == 3'b000;
  endproperty
  a_ctrl_high_zero: assert property (p_ctrl_high_zero) else $error("bits 7-5 not zero"); // R20

  property p_bad_key;
    (running && key_wr && wbyte != rwd_pkg::KEY_FIRST) |=> !key_armed_q;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("sequence armed by wrong key"); // R24

  c_por_done:    cover property (state_q == rwd_pkg::ST_START ##1 state_q == rwd_pkg::ST_RUN);
  c_key_service: cover property (key_complete && primary_s && wden_q);
  c_wdt_reset:   cover property (running && wdt_expire);
  c_pin_reset:   cover property (state_q == rwd_pkg::ST_PIN_HOLD);

endmodule // rwd_top
`default_nettype wire

// ---- test/rwd_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module rwd_board_model (
  // clock
  input  wire logic pclk,
  // board reset request from the bench
  input  wire logic ext_low,
  // device side of the open-drain wire
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  output logic      reset_pin_in
);
  logic [1:0] hold_q;
  logic [1:0] hold_d;

  // a press is stretched so the wire stays low at least two cycles
  assign hold_d = ext_low ? 2'h2 : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
  always_ff @(posedge pclk)
  begin
    hold_q <= hold_d;
  end

  // pull-up wins only when neither side pulls low
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || ext_low || (hold_q != 2'h0));
endmodule // rwd_board_model
`default_nettype wire

// ---- test/test_reset_and_watchdog_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_reset_and_watchdog_unit;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic        pin_in, pin_out, pin_oe, primary, fuse, tick, tick_run;
  logic        sys_reset, vector_load, flag, ext_low, leg_watch, oe_seen, e;
  int          n_errors, checked, n;

  rwd_top #(.BASE_DIV_LOG2(4), .LEGACY_DIV_LOG2(6)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .primary_config_mode(primary), .legacy_watchdog_fuse(fuse), .bus_clk_tick(tick),
    .sys_reset(sys_reset), .vector_load(vector_load), .watchdog_reset_flag(flag));

  rwd_board_model u_board (.pclk(pclk), .ext_low(ext_low), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .reset_pin_in(pin_in));

  // clock and a healthy bus clock indication
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (tick_run) tick <= ~tick;
    if (leg_watch && pin_oe === 1'b1) oe_seen <= 1'b1;
  end

  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) chk("pready", 1'b0, 1'b1);
  endtask

  // sel 0 watches sys_reset, 1 watches vector_load
  task wait_lvl(input int sel, input logic lvl, input int lim);
    for (n = 0; n < lim; n++)
    begin
      @(posedge pclk);
      if ((sel == 0 ? sys_reset : vector_load) === lvl) break;
    end
  endtask

  task do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // board holds the wire low past the power-on delay
  task t_por_primary;
    ext_low <= 1'b1;
    do_reset();
    for (int i = 0; i < 4200; i++)
    begin
      @(posedge pclk);
      if (i == 10) chk("oe_por", pin_oe, 1'b1);
      if (i == 4150) chk("held_low", sys_reset, 1'b1);
    end
    ext_low <= 1'b0;
    wait_lvl(1, 1'b1, 20);
    chk("vec_after_rise", n < 20, 1'b1);
    @(posedge pclk);
    chk("running", sys_reset, 1'b0);
  endtask

  task t_regs;
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("ctrl_rst", v, 0);
    apb(0, rwd_pkg::KEY_ADDR, 0); chk("key_read", v, 0);
    apb(0, 8'h00, 0); chk("unmapped", e, 1'b1);
    apb(1, rwd_pkg::CTRL_ADDR, 32'hffff_ffe5);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("ctrl_once", v, 32'h05);
    apb(1, rwd_pkg::CTRL_ADDR, 32'h02);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("ctrl_locked", v, 32'h05);
  endtask

  // period is 64 cycles with select code 01
  task t_service;
    repeat (4)
    begin
      apb(1, rwd_pkg::KEY_ADDR, rwd_pkg::KEY_FIRST);
      apb(0, rwd_pkg::CTRL_ADDR, 0);
      repeat (20) @(posedge pclk);
      apb(1, rwd_pkg::KEY_ADDR, rwd_pkg::KEY_SECOND);
    end
    chk("serviced", sys_reset, 1'b0);
    apb(1, rwd_pkg::KEY_ADDR, rwd_pkg::KEY_FIRST);
    apb(1, rwd_pkg::KEY_ADDR, 32'h12);
    apb(1, rwd_pkg::KEY_ADDR, rwd_pkg::KEY_SECOND);
    wait_lvl(0, 1'b1, 60);
    chk("expired", n < 60, 1'b1);
    oe_seen = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge pclk);
      if (pin_oe === 1'b1) oe_seen = 1'b1;
    end
    chk("oe_wdog", oe_seen, 1'b1);
    chk("pin_out_low", pin_out, 1'b0);
    wait_lvl(1, 1'b1, 40);
    chk("vec_wdog", n < 40, 1'b1);
    chk("flag_pin_set", flag, 1'b1);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("flag_set", v, 32'h10);
    @(posedge pclk);
    chk("flag_pin_clr", flag, 1'b0);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("flag_clr", v, 0);
  endtask

  task t_clkmon;
    apb(1, rwd_pkg::CTRL_ADDR, 32'h08);
    apb(1, rwd_pkg::CTRL_ADDR, 32'h00);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("clkmon_once", v, 32'h08);
    tick_run <= 1'b0;
    wait_lvl(0, 1'b1, 150);
    chk("clk_loss", n < 150, 1'b1);
    @(posedge pclk);
    chk("flag_pin_clkmon", flag, 1'b1);
    tick_run <= 1'b1;
    wait_lvl(1, 1'b1, 60);
    apb(0, rwd_pkg::CTRL_ADDR, 0); chk("flag_clkmon", v, 32'h10);
  endtask

  task t_pin;
    ext_low <= 1'b1;
    wait_lvl(0, 1'b1, 6);
    chk("pin_reset", n < 6, 1'b1);
    ext_low <= 1'b0;
    wait_lvl(1, 1'b1, 10);
    chk("vec_pin", n < 10, 1'b1);
  endtask

  task t_legacy;
    primary <= 1'b0;
    fuse <= 1'b1;
    leg_watch <= 1'b1;
    oe_seen = 1'b0;
    do_reset();
    wait_lvl(0, 1'b0, 5000);
    chk("por_len", (n >= 4064) && (n <= 4080), 1'b1);
    repeat (4)
    begin
      apb(1, rwd_pkg::LCLR_ADDR, 32'hfe);
      repeat (30) @(posedge pclk);
    end
    chk("leg_serviced", sys_reset, 1'b0);
    wait_lvl(0, 1'b1, 100);
    chk("leg_expired", n < 100, 1'b1);
    chk("oe_legacy", oe_seen, 1'b0);
  endtask

  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; primary = 1'b1; fuse = 1'b0; tick = 1'b0; tick_run = 1'b1;
    ext_low = 1'b0; leg_watch = 1'b0; oe_seen = 1'b0; n_errors = 0; checked = 0;
    @(posedge pclk);
    t_por_primary();
    t_regs();
    t_service();
    t_clkmon();
    t_pin();
    t_legacy();
    end_of_test();
  end

  // hang guard, well above the expected run
  initial
  begin
    #2000000;
    n_errors++;
    end_of_test();
  end
endmodule // test_reset_and_watchdog_unit
`default_nettype wire
